// ---- common/pll_sup_pkg.sv ----
// Constants, register map and enumerations for the PLL lock and clock-loss supervisor
package pll_sup_pkg;

   // System clock
   localparam int CLK_PERIOD_PS = 5000;

   // Reference or feedback silent for this long counts as lost
   localparam int LOSS_TIME_NS = 1000;
   localparam int LOSS_CYC     = (LOSS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOSS_W       = 9;

   // Lock detector windows in reference falling edges and tight tolerance
   localparam int LD_N         = 32;
   localparam int LD_K         = 8;
   localparam int LD_TOL_TIGHT = 1;
   localparam int LD_CNT_W     = 7;

   // Frequency plan: fsys = fref * 2 * (fd + 2) / 2**od, VCO at four times fsys
   localparam int MULT_BASE   = 2;
   localparam int MULT_OFFSET = 2;
   localparam int VCO_PER_SYS = 4;

   // Charge pump thresholds on the feedback divider
   localparam logic [2:0] PUMP_2X_MIN = 3'h2;
   localparam logic [2:0] PUMP_4X_MIN = 3'h6;

   // Strap capture delay after reset release
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_STAT  = 8'h04;
   localparam logic [7:0] OFS_CAUSE = 8'h08;

   // synth_control_reg fields
   localparam int CTRL_OD_LSB  = 0;
   localparam int CTRL_FD_LSB  = 4;
   localparam int CTRL_LDE_BIT = 8;
   localparam int CTRL_LRE_BIT = 9;
   localparam int CTRL_SRE_BIT = 10;

   // synth_status_reg fields
   localparam int STAT_LOCK_BIT   = 0;
   localparam int STAT_STICKY_BIT = 1;
   localparam int STAT_CLOSS_BIT  = 2;
   localparam int STAT_EXT_BIT    = 3;
   localparam int STAT_HOLD_BIT   = 4;
   localparam int STAT_SRC_LSB    = 5;
   localparam int STAT_PUMP_LSB   = 7;

   // reset_cause_register fields
   localparam int CAUSE_SYNC_BIT  = 0;
   localparam int CAUSE_INPUT_BIT = 1;

   // Startup values: 2 * (1 + 2) / 1 = six times the reference
   localparam logic [2:0] RST_OUT_DIV = 3'h0;
   localparam logic [2:0] RST_FB_DIV  = 3'h1;

   typedef enum logic [1:0] {
      SRC_PLL    = 2'b00,
      SRC_REF    = 2'b01,
      SRC_FREE   = 2'b10,
      SRC_STATIC = 2'b11
   } clk_src_type;

   typedef enum logic [1:0] {
      LD_ACQ_N  = 2'b00,
      LD_ACQ_NK = 2'b01,
      LD_LCK_N  = 2'b10,
      LD_LCK_NK = 2'b11
   } lock_state_type;

   typedef enum logic [1:0] {
      PUMP_1X = 2'b00,
      PUMP_2X = 2'b01,
      PUMP_4X = 2'b10
   } pump_type;

endpackage

// ---- core/pll_lock_and_clock_loss_supervisor.sv ----
// PLL lock detector, clock-loss supervisor, clock fallback and Wishbone registers
//
// Summary of operation
// - Multiplier 2*(fd+2) spans 4x to 18x of the reference.
// - Output divider sits outside the loop; rewriting it leaves lock alone.
// - UP when feedback falling edge lags reference, DOWN when it leads.
// - Pump strength 1x below 2, 2x from 2 to 5, 4x at 6+.
// - VCO runs at four times system rate, feedback divides it down.
// - Compare counts after N then N+K edges; lock then relax tolerance.
// - Locked detector keeps alternating; mismatch drops lock and restarts tight.
// - External clock mode disables PLL; lock never reported.
// - First lock sets live and sticky; feedback divider change or loss clears both.
// - Unlocked, system clock still taken from PLL output.
// - Relock sets live; sticky again only after a divider-change loss or a supervisor-raised reset.
// - PLL off in stop: sticky keeps pre-stop value after relock.
// - Lock-loss reset enable makes loss raise reset and log cause.
// - PLL mode reset held until reference present and lock achieved.
// - External mode: no lock-loss event, lock-loss reset enable ignored.
// - Clock-loss detect sets sticky flag when reference or feedback too slow.
// - Clock-loss detection off in external clock mode.
// - Clock-loss reset enable raises reset, logs cause, clears sticky flag.
// - Reference failure: free-running mode until next reset.
// - PLL failure: reference drives system until next reset.
// - Both fail: reference failure wins; static if free-run cannot run.
// - Any reset restores control and status to startup values; cause bits survive supervisor-raised resets, power-on reset clears them.
// - Both dividers take 0 to 7 in the frequency formula.
// - Startup dividers give six times the reference frequency.
// - Detect disabled when PLL fails: system clocks stop, static.
`timescale 1ns/1ps

module pll_lock_and_clock_loss_supervisor
   import pll_sup_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic [3:0]  i_wb_sel,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_ref_clk,
   input  wire logic        i_fb_clk,
   input  wire logic        i_ext_clk_mode,
   input  wire logic        i_free_run_ok,
   input  wire logic        i_stop_mode,
   input  wire logic        i_stop_pll_off,
   output logic      [2:0]  o_feedback_divider,
   output logic      [2:0]  o_output_divider,
   output logic      [6:0]  o_loop_div_ratio,
   output logic      [1:0]  o_pump_strength,
   output logic             o_pump_up,
   output logic             o_pump_down,
   output logic             o_pll_enable,
   output logic      [1:0]  o_clk_src,
   output logic             o_free_running_mode,
   output logic             o_sys_reset
);

   typedef struct packed {
      logic [1:0]          ref_sync;
      logic [1:0]          fb_sync;
      logic [1:0]          ext_sync;
      logic                ref_prev;
      logic                fb_prev;
      logic [1:0]          strap_cnt;
      logic                strap_done;
      logic                ext_mode;
      logic                hold;
      logic [2:0]          out_div;
      logic [2:0]          fb_div;
      logic                loss_det_en;
      logic                loss_rst_en;
      logic                sync_rst_en;
      lock_state_type      ld_state;
      logic [LD_CNT_W-1:0] ref_cnt;
      logic [LD_CNT_W-1:0] fb_cnt;
      logic                lock;
      logic                sticky;
      logic                rearm;
      logic                stop_hold;
      logic [LOSS_W-1:0]   ref_idle;
      logic [LOSS_W-1:0]   fb_idle;
      logic                ref_seen;
      logic                clk_loss;
      logic                free_run;
      logic                ref_src;
      logic                stalled;
      logic                cause_sync;
      logic                cause_input;
      logic                ack;
      logic [31:0]         rdata;
      logic                up;
      logic                down;
      pump_type            pump;
      logic [6:0]          ratio;
      clk_src_type         src;
   } state_type;

   localparam logic [LOSS_W-1:0]   LOSS_LIM = LOSS_W'(LOSS_CYC);
   localparam logic [LD_CNT_W-1:0] CNT_MAX  = '1;
   localparam logic [LD_CNT_W-1:0] WIN_N    = LD_CNT_W'(LD_N);
   localparam logic [LD_CNT_W-1:0] WIN_NK   = LD_CNT_W'(LD_N + LD_K);
   localparam logic [LD_CNT_W-1:0] TOL_T    = LD_CNT_W'(LD_TOL_TIGHT);
   localparam logic [LD_CNT_W-1:0] TOL_R    = LD_CNT_W'(2 * LD_TOL_TIGHT);

   state_type st_ff;
   state_type nxt_st;

   // Next-state logic for the whole block
   always_comb
   begin
      logic                ref_fall;
      logic                fb_fall;
      logic                ref_edge;
      logic                fb_edge;
      logic                ref_lost;
      logic                fb_lost;
      logic                pll_on;
      logic                mon;
      logic                req;
      logic                div_write;
      logic                lock_lost;
      logic                win_end;
      logic                match;
      logic                lol_evt;
      logic                loc_evt;
      logic [LD_CNT_W-1:0] win_len;
      logic [LD_CNT_W-1:0] tol;
      logic [LD_CNT_W-1:0] fb_now;
      logic [LD_CNT_W-1:0] ref_now;
      nxt_st    = st_ff;
      div_write = 1'b0;
      lock_lost = 1'b0;
      match     = 1'b0;

      // Pins cross in through two flops; edges are taken on the second
      nxt_st.ref_sync = {st_ff.ref_sync[0], i_ref_clk};
      nxt_st.fb_sync  = {st_ff.fb_sync[0], i_fb_clk};
      nxt_st.ext_sync = {st_ff.ext_sync[0], i_ext_clk_mode};
      nxt_st.ref_prev = st_ff.ref_sync[1];
      nxt_st.fb_prev  = st_ff.fb_sync[1];
      ref_fall = st_ff.ref_prev & ~st_ff.ref_sync[1];
      fb_fall  = st_ff.fb_prev & ~st_ff.fb_sync[1];
      ref_edge = st_ff.ref_prev ^ st_ff.ref_sync[1];
      fb_edge  = st_ff.fb_prev ^ st_ff.fb_sync[1];

      // Mode strap is caught once the synchroniser has settled
      if (!st_ff.strap_done)
      begin
         nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
         if (st_ff.strap_cnt == STRAP_WAIT)
         begin
            nxt_st.strap_done = 1'b1;
            nxt_st.ext_mode   = st_ff.ext_sync[1];
         end
      end
      pll_on = st_ff.strap_done & ~st_ff.ext_mode & ~st_ff.stalled;
      mon    = st_ff.strap_done & ~st_ff.ext_mode;

      // Silence timers; saturate so a dead clock stays flagged
      nxt_st.ref_idle = ref_edge ? '0 : (st_ff.ref_idle == LOSS_LIM) ? LOSS_LIM
                                       : st_ff.ref_idle + LOSS_W'(1);
      nxt_st.fb_idle  = fb_edge ? '0 : (st_ff.fb_idle == LOSS_LIM) ? LOSS_LIM
                                      : st_ff.fb_idle + LOSS_W'(1);
      ref_lost = (st_ff.ref_idle == LOSS_LIM);
      fb_lost  = (st_ff.fb_idle == LOSS_LIM);
      if (ref_edge)
         nxt_st.ref_seen = 1'b1;

      // Wishbone slave: one wait state, unmapped reads return zero
      req        = i_wb_cyc & i_wb_stb & ~st_ff.ack;
      nxt_st.ack = req;
      if (req)
      begin
         case (i_wb_adr)
            OFS_CTRL:
            begin
               nxt_st.rdata = '0;
               nxt_st.rdata[CTRL_OD_LSB +: 3] = st_ff.out_div;
               nxt_st.rdata[CTRL_FD_LSB +: 3] = st_ff.fb_div;
               nxt_st.rdata[CTRL_LDE_BIT]     = st_ff.loss_det_en;
               nxt_st.rdata[CTRL_LRE_BIT]     = st_ff.loss_rst_en;
               nxt_st.rdata[CTRL_SRE_BIT]     = st_ff.sync_rst_en;
            end
            OFS_STAT:
            begin
               nxt_st.rdata = '0;
               nxt_st.rdata[STAT_LOCK_BIT]      = st_ff.lock;
               nxt_st.rdata[STAT_STICKY_BIT]    = st_ff.sticky;
               nxt_st.rdata[STAT_CLOSS_BIT]     = st_ff.clk_loss;
               nxt_st.rdata[STAT_EXT_BIT]       = st_ff.ext_mode;
               nxt_st.rdata[STAT_HOLD_BIT]      = st_ff.hold;
               nxt_st.rdata[STAT_SRC_LSB +: 2]  = st_ff.src;
               nxt_st.rdata[STAT_PUMP_LSB +: 2] = st_ff.pump;
            end
            OFS_CAUSE:
            begin
               nxt_st.rdata = '0;
               nxt_st.rdata[CAUSE_SYNC_BIT]  = st_ff.cause_sync;
               nxt_st.rdata[CAUSE_INPUT_BIT] = st_ff.cause_input;
            end
            default:
               nxt_st.rdata = '0;
         endcase
         if (i_wb_we && i_wb_adr == OFS_CTRL && i_wb_sel[0])
         begin
            nxt_st.out_div = i_wb_dat[CTRL_OD_LSB +: 3];
            nxt_st.fb_div  = i_wb_dat[CTRL_FD_LSB +: 3];
            div_write      = (i_wb_dat[CTRL_FD_LSB +: 3] != st_ff.fb_div);
         end
         if (i_wb_we && i_wb_adr == OFS_CTRL && i_wb_sel[1])
         begin
            nxt_st.loss_det_en = i_wb_dat[CTRL_LDE_BIT];
            nxt_st.loss_rst_en = i_wb_dat[CTRL_LRE_BIT];
            nxt_st.sync_rst_en = i_wb_dat[CTRL_SRE_BIT];
         end
         // Write one to clear; a new cause below wins
         if (i_wb_we && i_wb_adr == OFS_CAUSE && i_wb_sel[0])
         begin
            if (i_wb_dat[CAUSE_SYNC_BIT])
               nxt_st.cause_sync = 1'b0;
            if (i_wb_dat[CAUSE_INPUT_BIT])
               nxt_st.cause_input = 1'b0;
         end
      end

      // Stop with PLL switched off freezes the sticky flag
      if (i_stop_mode && i_stop_pll_off)
         nxt_st.stop_hold = 1'b1;

      // Two-counter lock detector
      win_len = st_ff.ld_state[0] ? WIN_NK : WIN_N;
      tol     = st_ff.ld_state[1] ? TOL_R : TOL_T;
      fb_now  = (fb_fall && st_ff.fb_cnt != CNT_MAX) ? st_ff.fb_cnt + LD_CNT_W'(1)
                                                     : st_ff.fb_cnt;
      ref_now = st_ff.ref_cnt + LD_CNT_W'(1);
      win_end = ref_fall & (ref_now == win_len);
      if (!pll_on)
      begin
         nxt_st.ld_state = LD_ACQ_N;
         nxt_st.ref_cnt  = '0;
         nxt_st.fb_cnt   = '0;
         nxt_st.lock     = 1'b0;
      end
      else if (div_write)
      begin
         // Divider change: expected loss, sticky returns on relock
         nxt_st.ld_state = LD_ACQ_N;
         nxt_st.ref_cnt  = '0;
         nxt_st.fb_cnt   = '0;
         nxt_st.lock     = 1'b0;
         nxt_st.rearm    = 1'b1;
         if (!st_ff.stop_hold)
            nxt_st.sticky = 1'b0;
      end
      else if (win_end)
      begin
         nxt_st.ref_cnt = '0;
         nxt_st.fb_cnt  = '0;
         match = (fb_now + tol >= win_len) && (fb_now <= win_len + tol);
         case (st_ff.ld_state)
            LD_ACQ_N:
               nxt_st.ld_state = match ? LD_ACQ_NK : LD_ACQ_N;
            LD_ACQ_NK:
            begin
               if (match)
               begin
                  nxt_st.ld_state = LD_LCK_N;
                  nxt_st.lock     = 1'b1;
                  if (st_ff.stop_hold)
                  begin
                     if (!i_stop_mode)
                        nxt_st.stop_hold = 1'b0;
                  end
                  else if (st_ff.rearm)
                     nxt_st.sticky = 1'b1;
                  nxt_st.rearm = 1'b0;
               end
               else
                  nxt_st.ld_state = LD_ACQ_N;
            end
            LD_LCK_N:
            begin
               nxt_st.ld_state = match ? LD_LCK_NK : LD_ACQ_N;
               lock_lost       = ~match;
            end
            LD_LCK_NK:
            begin
               nxt_st.ld_state = match ? LD_LCK_N : LD_ACQ_N;
               lock_lost       = ~match;
            end
            default:
               nxt_st.ld_state = LD_ACQ_N;
         endcase
      end
      else
      begin
         if (ref_fall)
            nxt_st.ref_cnt = ref_now;
         nxt_st.fb_cnt = fb_now;
      end
      if (lock_lost)
      begin
         // Unexpected loss: sticky stays clear after relock unless the loss also raises reset
         nxt_st.lock  = 1'b0;
         nxt_st.rearm = 1'b0;
         if (!st_ff.stop_hold)
            nxt_st.sticky = 1'b0;
      end

      // Clock-loss flag and fallback selection
      if (mon && st_ff.loss_det_en && (ref_lost || fb_lost))
         nxt_st.clk_loss = 1'b1;
      if (mon && !st_ff.hold)
      begin
         if (st_ff.loss_det_en && ref_lost)
            nxt_st.free_run = 1'b1;
         else if (st_ff.loss_det_en && fb_lost && !st_ff.free_run)
            nxt_st.ref_src = 1'b1;
         if (st_ff.free_run && !i_free_run_ok)
            nxt_st.stalled = 1'b1;
         if (!st_ff.loss_det_en && fb_lost)
            nxt_st.stalled = 1'b1;
      end

      // Reset requests; stop-mode lock losses are intended and raise none, clock losses still do
      lol_evt = lock_lost & st_ff.sync_rst_en & mon & ~st_ff.hold
                & ~st_ff.stop_hold;
      loc_evt = mon & ~st_ff.hold & st_ff.loss_det_en & st_ff.loss_rst_en
                & (ref_lost | fb_lost);
      if (lol_evt)
         nxt_st.cause_sync = 1'b1;
      if (loc_evt)
         nxt_st.cause_input = 1'b1;
      if (lol_evt || loc_evt)
      begin
         nxt_st.hold     = 1'b1;
         nxt_st.ld_state = LD_ACQ_N;
         nxt_st.ref_cnt  = '0;
         nxt_st.fb_cnt   = '0;
         nxt_st.lock     = 1'b0;
         nxt_st.sticky   = 1'b0;
         nxt_st.rearm    = 1'b1;
      end
      else if (st_ff.hold && st_ff.strap_done && st_ff.ref_seen && !ref_lost
               && (st_ff.ext_mode || st_ff.lock))
         nxt_st.hold = 1'b0;

      // While reset is held the control state sits at startup values
      if (nxt_st.hold)
      begin
         nxt_st.out_div     = RST_OUT_DIV;
         nxt_st.fb_div      = RST_FB_DIV;
         nxt_st.loss_det_en = 1'b0;
         nxt_st.loss_rst_en = 1'b0;
         nxt_st.sync_rst_en = 1'b0;
         nxt_st.clk_loss    = 1'b0;
         nxt_st.free_run    = 1'b0;
         nxt_st.ref_src     = 1'b0;
         nxt_st.stalled     = 1'b0;
         nxt_st.stop_hold   = 1'b0;
      end

      // Phase detector on falling edges; pulses shrink to slivers once locked
      if (!pll_on || (ref_fall && fb_fall))
      begin
         nxt_st.up   = 1'b0;
         nxt_st.down = 1'b0;
      end
      else if (ref_fall)
      begin
         nxt_st.up   = ~st_ff.down;
         nxt_st.down = 1'b0;
      end
      else if (fb_fall)
      begin
         nxt_st.down = ~st_ff.up;
         nxt_st.up   = 1'b0;
      end

      // Pump strength and loop ratio follow the feedback divider
      if (nxt_st.fb_div >= PUMP_4X_MIN)
         nxt_st.pump = PUMP_4X;
      else if (nxt_st.fb_div >= PUMP_2X_MIN)
         nxt_st.pump = PUMP_2X;
      else
         nxt_st.pump = PUMP_1X;
      nxt_st.ratio = 7'(VCO_PER_SYS * MULT_BASE
                        * (int'(nxt_st.fb_div) + MULT_OFFSET));

      // Clock source; unlocked PLL still drives the system
      if (nxt_st.stalled)
         nxt_st.src = SRC_STATIC;
      else if (nxt_st.ext_mode)
         nxt_st.src = SRC_REF;
      else if (nxt_st.hold)
         nxt_st.src = (!nxt_st.ref_seen || ref_lost) ? SRC_FREE : SRC_PLL;
      else if (nxt_st.free_run)
         nxt_st.src = SRC_FREE;
      else if (nxt_st.ref_src)
         nxt_st.src = SRC_REF;
      else
         nxt_st.src = SRC_PLL;
   end

   // State register; power-on enters held reset at startup values
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_ff          <= '0;
         st_ff.hold     <= 1'b1;
         st_ff.out_div  <= RST_OUT_DIV;
         st_ff.fb_div   <= RST_FB_DIV;
         st_ff.rearm    <= 1'b1;
         st_ff.ld_state <= LD_ACQ_N;
         st_ff.pump     <= PUMP_1X;
         st_ff.ratio    <= 7'(VCO_PER_SYS * MULT_BASE * (1 + MULT_OFFSET));
         st_ff.src      <= SRC_FREE;
      end
      else
         st_ff <= nxt_st;
   end

   // Outputs straight from the state register
   assign o_wb_dat            = st_ff.rdata;
   assign o_wb_ack            = st_ff.ack;
   assign o_feedback_divider  = st_ff.fb_div;
   assign o_output_divider    = st_ff.out_div;
   assign o_loop_div_ratio    = st_ff.ratio;
   assign o_pump_strength     = st_ff.pump;
   assign o_pump_up           = st_ff.up;
   assign o_pump_down         = st_ff.down;
   assign o_pll_enable        = st_ff.strap_done & ~st_ff.ext_mode;
   assign o_clk_src           = st_ff.src;
   assign o_free_running_mode = (st_ff.src == SRC_FREE);
   assign o_sys_reset         = st_ff.hold;

endmodule

// ---- tb/pll_lock_and_clock_loss_supervisor_tb_top.sv ----
// Testbench: reset, lock, divider sweep, clock loss and fallback
`timescale 1ns/1ps
module pll_lock_and_clock_loss_supervisor_tb_top;
   import pll_sup_pkg::*;
   logic        i_clk, i_arst_n, stb, we, ref_run, fb_run, ref_clk, o_wb_ack, o_pump_up;
   logic        o_pump_down, o_pll_enable, o_free_running_mode, o_sys_reset;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rd, rnd, o_wb_dat;
   logic [2:0]  o_feedback_divider, o_output_divider, fdv;
   logic [6:0]  o_loop_div_ratio;
   logic [1:0]  o_pump_strength, o_clk_src;
   int          fails, samples_checked, i;
   pll_ref_src u_ref (.i_run(ref_run), .o_ref_clk(ref_clk));
   // Ideal loop: feedback copies the reference unless it is made to fail
   pll_lock_and_clock_loss_supervisor dut (.i_clk, .i_arst_n, .i_wb_cyc(stb), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat, .o_wb_ack,
      .i_ref_clk(ref_clk), .i_fb_clk(ref_clk & fb_run), .i_ext_clk_mode(1'b0),
      .i_free_run_ok(1'b1), .i_stop_mode(1'b0), .i_stop_pll_off(1'b0), .o_feedback_divider,
      .o_output_divider, .o_loop_div_ratio, .o_pump_strength, .o_pump_up, .o_pump_down,
      .o_pll_enable, .o_clk_src, .o_free_running_mode, .o_sys_reset);
   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Model pump strength from the divider thresholds
   function automatic logic [1:0] pump(input logic [2:0] f);
      return f < 3'h2 ? 2'b00 : (f < 3'h6 ? 2'b01 : 2'b10);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle; waits for ack, no fixed latency assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do @(posedge i_clk); while (o_wb_ack !== 1'b1 && ++n < 50);
      rd = o_wb_dat;
      stb <= 1'b0;
      if (n >= 50) fails++;
   endtask
   task automatic poll_lock;
      i = 0;
      do bus(1'b0, OFS_STAT, 32'h0); while (rd[0] !== 1'b1 && ++i < 400);
      if (i >= 400) fails++;
      // Held reset drops one cycle after lock, so take a fresh status word
      bus(1'b0, OFS_STAT, 32'h0);
   endtask
   task automatic do_reset;
      i_arst_n <= 1'b0;
      repeat (12) @(posedge i_clk);
      i_arst_n <= 1'b1;
      ref_run <= 1'b1;
      fb_run <= 1'b1;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard, far beyond the few thousand cycles the sequence needs
   initial
   begin
      #200us;
      fails++;
      end_sim;
   end
   initial
   begin
      {i_arst_n, stb, we, adr, wdat, sel} = '0;
      // Oscillator enables start known; an unknown would latch the model clock at X
      {ref_run, fb_run} = 2'h0;
      rnd = 32'h97c9;
      do_reset;
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h10);
      bus(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      poll_lock;
      chk(rd[6:0], 7'h03);
      // Sweep every feedback divider with random output divider; ends back at 1
      for (int k = 0; k < 8; k++)
      begin
         fdv = 3'(k + 2);
         rnd = lfsr(rnd);
         bus(1'b1, OFS_CTRL, {25'h0, fdv, 1'b0, rnd[2:0]});
         repeat (2) @(posedge i_clk);
         chk({o_feedback_divider, o_output_divider, o_pump_strength, o_loop_div_ratio},
            {fdv, rnd[2:0], pump(fdv), 7'(8 * (fdv + 3'h2))});
         bus(1'b0, OFS_STAT, 32'h0);
         chk(rd[1:0], 2'b00);
      end
      poll_lock;
      chk(rd[1:0], 2'b11);
      bus(1'b1, OFS_CTRL, 32'h115);
      bus(1'b0, OFS_STAT, 32'h0);
      chk(rd[1:0], 2'b11);
      fb_run <= 1'b0;
      repeat (300) @(posedge i_clk);
      bus(1'b0, OFS_STAT, 32'h0);
      chk({rd[6:5], rd[2]}, 3'b011);
      fb_run <= 1'b1;
      repeat (1000) @(posedge i_clk);
      chk(o_clk_src, SRC_REF);
      do_reset;
      poll_lock;
      bus(1'b1, OFS_CTRL, 32'h310);
      ref_run <= 1'b0;
      repeat (300) @(posedge i_clk);
      bus(1'b0, OFS_CAUSE, 32'h0);
      chk({o_sys_reset, o_clk_src, rd[1:0]}, 5'b11010);
      end_sim;
   end
endmodule

// ---- tb/pll_ref_src.sv ----
// Reference clock source model: oscillator that can fail
`timescale 1ns/1ps
module pll_ref_src #(parameter realtime HALF = 21.3)
(
   input  wire logic i_run,
   output logic      o_ref_clk
);
   // A dead oscillator settles low instead of freezing at its last level
   initial
   begin
      o_ref_clk = 1'b0;
      forever
      begin
         #(HALF);
         o_ref_clk = i_run ? ~o_ref_clk : 1'b0;
      end
   end
endmodule

// ---- tb/pll_sup_chk.sv ----
// Port checker for the supervisor: bus handshake, pump, ratio, clock source
`timescale 1ns/1ps
module pll_sup_chk
   import pll_sup_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        o_wb_ack,
   input  wire logic [2:0]  o_feedback_divider,
   input  wire logic [6:0]  o_loop_div_ratio,
   input  wire logic [1:0]  o_pump_strength,
   input  wire logic        o_pump_up,
   input  wire logic        o_pump_down,
   input  wire logic        o_pll_enable,
   input  wire logic [1:0]  o_clk_src,
   input  wire logic        o_free_running_mode,
   input  wire logic        o_sys_reset
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Stable divider checks; pump and ratio are registered in the same cycle as the divider
   chk_pump_map: assert property ($stable(o_feedback_divider) |-> o_pump_strength ==
      (o_feedback_divider < 3'h2 ? 2'b00 : o_feedback_divider < 3'h6 ? 2'b01 : 2'b10))
      else $error("pump strength does not follow divider");
   chk_loop_ratio: assert property ($stable(o_feedback_divider) |->
      o_loop_div_ratio == 8 * (o_feedback_divider + 2)) else $error("loop ratio wrong");
   chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("bus request not acknowledged");
   chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
   chk_free_flag: assert property (o_free_running_mode == (o_clk_src == SRC_FREE))
      else $error("free running flag disagrees with source");
   chk_pump_off: assert property (!o_pll_enable ##1 !o_pll_enable |->
      !o_pump_up && !o_pump_down) else $error("pump active with loop off");
   chk_ref_held: assert property (o_clk_src == SRC_REF && !o_sys_reset |=>
      o_clk_src != SRC_PLL || o_sys_reset) else $error("left reference fallback");
   chk_free_held: assert property (o_clk_src == SRC_FREE && !o_sys_reset &&
      !$past(o_sys_reset) |=> o_clk_src inside {SRC_FREE, SRC_STATIC} || o_sys_reset)
      else $error("left free running fallback");
endmodule
bind pll_lock_and_clock_loss_supervisor pll_sup_chk u_chk (.i_clk, .i_arst_n, .i_wb_cyc,
   .i_wb_stb, .o_wb_ack, .o_feedback_divider, .o_loop_div_ratio, .o_pump_strength,
   .o_pump_up, .o_pump_down, .o_pll_enable, .o_clk_src, .o_free_running_mode, .o_sys_reset);
